//--- logic/sbd_host.sv
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ns
// Function
// - Busy descriptor bit 31 marks flag present
// - Busy polarity bit 30 decides active level
// - Busy descriptor bit 29 reads zero
// - Bit 28 selects addressed or direct access
// - Bit 27 puts register address byte 1
// - Byte-1 placement forbidden with 8-bit addressing
// - Bits 26-24 give flag bit position
// - Addressed: bits 23-16 hold register address
// - Direct: bits 23-20 flag supported modes
// - Direct: bits 19-16 give dummy cycles
// - Single-lane mode works with no dummies
// - Clear mode flag does not mean unusable
// - Bits 15-8 read opcode, 00h none
// - Bits 7-0 write opcode, 00h none
// - Latch descriptor bit 31 marks flag present
// - Latch polarity bit 30 decides enabled level
// - Latch bit 29: bit field or direct set
// - Reserved descriptor bits read as zero
module sbd_host import sbd_pkg::*; (
	input logic pclk,
	input logic presetn,
	input logic [ADDR_W-1:0] paddr,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	sbd_link_if.host link
);
	typedef enum logic [2:0] {ST_IDLE, ST_DESC0, ST_DESC1, ST_POLL, ST_PPOLL, ST_PROG, ST_LATCH_W,
		ST_LATCH_R} sbd_state_type;

	sbd_state_type state_reg, state_next;
	sbd_opc_type op_cfg_reg;
	sbd_mode_type mode_cfg_reg, mode_reg;
	logic [3:0] dummy_cfg_reg, dummy_reg, nx_dummy;
	logic [1:0] aw_cfg_reg;
	logic [31:0] dsc_reg [NUM_DESC];
	logic [31:0] addr_reg, prdata_reg, nx_addr;
	logic [7:0] opcode_reg, wdata_reg, byte_reg, nx_op, nx_wdata;
	logic req_reg, done_reg, err_reg, busy_act_reg, latch_on_reg, pready_reg, pslverr_reg;
	logic [NUM_DESC-1:0] avail, pol, direct_set, addr_bad;
	logic [NUM_DESC-1:0][2:0] pos;
	logic [NUM_DESC-1:0][7:0] rd_op, wr_op;
	logic [NUM_DESC-1:0][3:0] dummy;
	logic [NUM_DESC-1:0][31:0] cmd_addr;
	logic wr_en, start, ans, fail, flag_now, cur, nx_bad;

	// Offsets the slave answers to
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_DESC0) || (a == REG_DESC1);
	endfunction

	// ----------------------------------------
	// Descriptor decoders, one per fetched word
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_DESC; gi++) begin : g_dec
			sbd_desc_decode u_dec (
				.word(dsc_reg[gi]), .mode(mode_cfg_reg), .dummy_ovr(dummy_cfg_reg), .addr_width(aw_cfg_reg),
				.avail(avail[gi]), .pol(pol[gi]), .direct_set(direct_set[gi]), .pos(pos[gi]),
				.rd_op(rd_op[gi]), .wr_op(wr_op[gi]), .dummy(dummy[gi]), .cmd_addr(cmd_addr[gi]),
				.addr_bad(addr_bad[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// Next command from the current step
	// ----------------------------------------
	assign cur = (state_reg == ST_LATCH_W) || (state_reg == ST_LATCH_R);

	// Missing flag or 00h opcode ends the operation with an error
	always_comb begin
		nx_op = OP_NONE;
		nx_addr = '0;
		nx_dummy = '0;
		nx_wdata = '0;
		nx_bad = 1'b0;
		case (state_reg)
			ST_DESC0: begin
				nx_op = OP_DESC_RD;
				nx_addr = 32'(DI_BUSY);
			end
			ST_DESC1: begin
				nx_op = OP_DESC_RD;
				nx_addr = 32'(DI_LATCH);
			end
			ST_POLL, ST_PPOLL, ST_LATCH_R: begin
				nx_op = rd_op[cur];
				nx_addr = cmd_addr[cur];
				nx_dummy = dummy[cur];
				nx_bad = !avail[cur] || rd_op[cur] == OP_NONE || addr_bad[cur];
			end
			ST_LATCH_W: begin
				nx_op = wr_op[DI_LATCH];
				nx_addr = cmd_addr[DI_LATCH];
				nx_dummy = dummy[DI_LATCH];
				if (!direct_set[DI_LATCH]) begin
					nx_wdata[pos[DI_LATCH]] = ~pol[DI_LATCH];
				end
				nx_bad = !avail[DI_LATCH] || wr_op[DI_LATCH] == OP_NONE || addr_bad[DI_LATCH];
			end
			ST_PROG: begin
				nx_op = OP_PROGRAM;
			end
			default: begin
				nx_op = OP_NONE;
			end
		endcase
	end

	assign ans = req_reg && link.ack && !link.err;
	assign fail = (state_reg != ST_IDLE && !req_reg && nx_bad) || (req_reg && link.ack && link.err);
	assign flag_now = flag_active(link.rdata[0 +: BYTE_W], pos[cur], pol[cur]);
	assign wr_en = psel && penable && pready_reg && pwrite;
	assign start = wr_en && paddr == REG_CTRL && pwdata[C_GO] && state_reg == ST_IDLE;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		if (state_reg == ST_IDLE) begin
			if (start) begin
				case (sbd_opc_type'(pwdata[C_OP +: MODE_W]))
					OPC_FETCH: state_next = ST_DESC0;
					OPC_POLL: state_next = ST_POLL;
					OPC_LATCH: state_next = ST_LATCH_W;
					OPC_PROGRAM: state_next = ST_PPOLL;
					default: state_next = ST_IDLE;
				endcase
			end
		end else if (fail) begin
			state_next = ST_IDLE;
		end else if (ans) begin
			case (state_reg)
				ST_DESC0: state_next = ST_DESC1;
				ST_PPOLL: state_next = flag_now ? ST_PPOLL : ST_PROG;
				ST_LATCH_W: state_next = (rd_op[DI_LATCH] != OP_NONE) ? ST_LATCH_R : ST_IDLE;
				default: state_next = ST_IDLE;
			endcase
		end
	end

	// State and link request; fields held until the answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			req_reg <= 1'b0;
			opcode_reg <= '0;
			addr_reg <= '0;
			mode_reg <= MODE_1S;
			dummy_reg <= '0;
			wdata_reg <= '0;
		end else begin
			state_reg <= state_next;
			if (req_reg) begin
				req_reg <= !link.ack;
			end else if (state_reg != ST_IDLE && !nx_bad) begin
				req_reg <= 1'b1;
				opcode_reg <= nx_op;
				addr_reg <= nx_addr;
				mode_reg <= mode_cfg_reg;
				dummy_reg <= nx_dummy;
				wdata_reg <= nx_wdata;
			end
		end
	end

	// Results of the operation
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_reg <= 1'b0;
			err_reg <= 1'b0;
			busy_act_reg <= 1'b0;
			latch_on_reg <= 1'b0;
			byte_reg <= '0;
			dsc_reg <= '{default: '0};
		end else if (start) begin
			done_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			if (state_reg != ST_IDLE && state_next == ST_IDLE) begin
				done_reg <= 1'b1;
				err_reg <= fail;
			end
			if (ans) begin
				byte_reg <= link.rdata[0 +: BYTE_W];
				case (state_reg)
					ST_DESC0: dsc_reg[DI_BUSY] <= link.rdata;
					ST_DESC1: dsc_reg[DI_LATCH] <= link.rdata;
					ST_POLL, ST_PPOLL: busy_act_reg <= flag_now;
					ST_LATCH_R: latch_on_reg <= flag_now;
					default: byte_reg <= link.rdata[0 +: BYTE_W];
				endcase
			end
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// Settings change only while idle so a running command stays coherent
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_cfg_reg <= OPC_FETCH;
			mode_cfg_reg <= MODE_1S;
			dummy_cfg_reg <= '0;
			aw_cfg_reg <= AW8;
		end else if (wr_en && paddr == REG_CTRL && state_reg == ST_IDLE) begin
			op_cfg_reg <= sbd_opc_type'(pwdata[C_OP +: MODE_W]);
			mode_cfg_reg <= sbd_mode_type'(pwdata[C_MODE +: MODE_W]);
			dummy_cfg_reg <= pwdata[C_DUMMY +: DUMMY_W];
			aw_cfg_reg <= pwdata[C_AW +: AW_W];
		end
	end

	// Zero-wait answer: ready in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= '0;
		end else begin
			pready_reg <= psel && !penable;
			pslverr_reg <= psel && !penable && !mapped(paddr);
			prdata_reg <= '0;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					REG_CTRL: begin
						prdata_reg[C_OP +: MODE_W] <= op_cfg_reg;
						prdata_reg[C_MODE +: MODE_W] <= mode_cfg_reg;
						prdata_reg[C_DUMMY +: DUMMY_W] <= dummy_cfg_reg;
						prdata_reg[C_AW +: AW_W] <= aw_cfg_reg;
					end
					REG_STATUS: begin
						prdata_reg[S_RUN] <= state_reg != ST_IDLE;
						prdata_reg[S_DONE] <= done_reg;
						prdata_reg[S_ERR] <= err_reg;
						prdata_reg[S_BUSY] <= busy_act_reg;
						prdata_reg[S_LATCH] <= latch_on_reg;
						prdata_reg[S_BYTE +: BYTE_W] <= byte_reg;
					end
					REG_DESC0: prdata_reg <= dsc_reg[DI_BUSY];
					REG_DESC1: prdata_reg <= dsc_reg[DI_LATCH];
					default: prdata_reg <= '0;
				endcase
			end
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign link.req = req_reg;
	assign link.opcode = opcode_reg;
	assign link.addr = addr_reg;
	assign link.mode = mode_reg;
	assign link.dummy = dummy_reg;
	assign link.wdata = wdata_reg;
endmodule

//--- logic/sbd_pkg.sv
package sbd_pkg;
	// ----------------------------------------
	// Descriptor field layout
	// ----------------------------------------
	localparam int F_AVAIL = 31;
	localparam int F_POL = 30;
	localparam int F_B29 = 29;
	localparam int F_ADDRD = 28;
	localparam int F_BYTE1 = 27;
	localparam int F_POS = 24;
	localparam int F_LADDR = 16;
	localparam int F_M8D = 23;
	localparam int F_M8S = 22;
	localparam int F_M4D = 21;
	localparam int F_M4S = 20;
	localparam int F_DUMMY = 16;
	localparam int F_RDOP = 8;
	localparam int F_WROP = 0;
	localparam int POS_W = 3;
	localparam int BYTE_W = 8;
	localparam int DUMMY_W = 4;
	localparam int MODE_W = 3;
	localparam int AW_W = 2;
	localparam int DI_BUSY = 0;
	localparam int DI_LATCH = 1;
	localparam int NUM_DESC = 2;

	// ----------------------------------------
	// Descriptor contents and device command set
	// ----------------------------------------
	localparam logic [31:0] BUSY_DESC = 32'h80580500;
	localparam logic [31:0] LATCH_DESC = 32'hb9026506;
	localparam logic [31:0] BUSY_RSVD_MASK = 32'h20000000;
	localparam logic [7:0] OP_NONE = 8'h00;
	localparam logic [7:0] OP_DESC_RD = 8'h5a;
	localparam logic [7:0] OP_PROGRAM = 8'h02;
	localparam int PROG_TIME_NS = 2000;
	localparam int CLK_PERIOD_NS = 20;
	localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROG_CNT_W = 8;

	typedef enum logic [2:0] {MODE_1S, MODE_4S, MODE_4D, MODE_8S, MODE_8D} sbd_mode_type;
	typedef enum logic [2:0] {OPC_FETCH, OPC_POLL, OPC_LATCH, OPC_PROGRAM} sbd_opc_type;

	// ----------------------------------------
	// Register map of the controller
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_DESC0 = 8'h08;
	localparam logic [7:0] REG_DESC1 = 8'h0c;
	localparam int C_GO = 0;
	localparam int C_OP = 1;
	localparam int C_MODE = 4;
	localparam int C_DUMMY = 8;
	localparam int C_AW = 12;
	localparam logic [1:0] AW8 = 2'h0;
	localparam int S_RUN = 0;
	localparam int S_DONE = 1;
	localparam int S_ERR = 2;
	localparam int S_BUSY = 3;
	localparam int S_LATCH = 4;
	localparam int S_BYTE = 8;

	// Support bit of a direct command for one mode
	function automatic logic mode_flag(input logic [31:0] w, input sbd_mode_type m);
		case (m)
			MODE_8D: mode_flag = w[F_M8D];
			MODE_8S: mode_flag = w[F_M8S];
			MODE_4D: mode_flag = w[F_M4D];
			MODE_4S: mode_flag = w[F_M4S];
			default: mode_flag = 1'b0;
		endcase
	endfunction

	// Raw register bit turned into an active/inactive meaning
	function automatic logic flag_active(input logic [7:0] b, input logic [2:0] pos, input logic pol);
		flag_active = b[pos] ^ pol;
	endfunction

	// Register address taken out of a command address
	function automatic logic [7:0] local_addr(input logic [31:0] w, input logic [31:0] a);
		local_addr = w[F_BYTE1] ? a[BYTE_W +: BYTE_W] : a[0 +: BYTE_W];
	endfunction
endpackage

//--- logic/sbd_link_if.sv
`timescale 1ns/1ns
interface sbd_link_if;
	logic req;
	logic [7:0] opcode;
	logic [31:0] addr;
	sbd_pkg::sbd_mode_type mode;
	logic [3:0] dummy;
	logic [7:0] wdata;
	logic ack;
	logic err;
	logic [31:0] rdata;
	modport host(output req, opcode, addr, mode, dummy, wdata, input ack, err, rdata);
	modport dev(input req, opcode, addr, mode, dummy, wdata, output ack, err, rdata);
endinterface

//--- logic/sbd_desc_decode.sv
`timescale 1ns/1ns
module sbd_desc_decode import sbd_pkg::*; (
	input logic [31:0] word,
	input sbd_mode_type mode,
	input logic [3:0] dummy_ovr,
	input logic [1:0] addr_width,
	output logic avail,
	output logic pol,
	output logic direct_set,
	output logic [2:0] pos,
	output logic [7:0] rd_op,
	output logic [7:0] wr_op,
	output logic [3:0] dummy,
	output logic [31:0] cmd_addr,
	output logic addr_bad
);
	logic [7:0] laddr;

	// ----------------------------------------
	// Plain fields
	// ----------------------------------------
	assign avail = word[F_AVAIL];
	assign pol = word[F_POL];
	assign direct_set = word[F_B29];
	assign pos = word[F_POS +: POS_W];
	assign rd_op = word[F_RDOP +: BYTE_W];
	assign wr_op = word[F_WROP +: BYTE_W];
	assign laddr = word[F_LADDR +: BYTE_W];

	// ----------------------------------------
	// Command address and dummy count
	// ----------------------------------------
	// Addressed commands put the register address in byte 0 or byte 1
	always_comb begin
		cmd_addr = '0;
		if (word[F_ADDRD]) begin
			cmd_addr = word[F_BYTE1] ? {16'h0000, laddr, 8'h00} : {24'h000000, laddr};
		end
	end

	// Byte-1 placement has no meaning with one address byte
	assign addr_bad = word[F_ADDRD] && word[F_BYTE1] && (addr_width == AW8);

	// Clear support bit is not a refusal: fall back to software count
	always_comb begin
		if (word[F_ADDRD]) begin
			dummy = dummy_ovr;
		end else if (mode == MODE_1S) begin
			dummy = '0;
		end else if (mode_flag(word, mode)) begin
			dummy = word[F_DUMMY +: DUMMY_W];
		end else begin
			dummy = dummy_ovr;
		end
	end
endmodule

//--- logic/sbd_device.sv
`timescale 1ns/1ns
module sbd_device import sbd_pkg::*; (
	input logic pclk,
	input logic presetn,
	sbd_link_if.dev link,
	output logic write_busy_flag,
	output logic write_latch_flag
);
	// Reserved bit forced clear whatever the table constant holds
	localparam logic [31:0] BUSY_WORD = BUSY_DESC & ~BUSY_RSVD_MASK;

	logic busy_reg;
	logic latch_reg;
	logic ack_reg;
	logic err_reg;
	logic [31:0] rdata_reg;
	logic [PROG_CNT_W-1:0] cnt_reg;
	logic take;
	logic desc_rd;
	logic rd_hit;
	logic wr_hit;
	logic prog_start;
	logic [7:0] stat_byte;

	// Dummy count check: 1-1-1 needs none, flagged modes the listed count
	function automatic logic cmd_ok(input logic [31:0] w, input logic [31:0] a, input sbd_mode_type m,
		input logic [3:0] d);
		logic dok;
		if (w[F_ADDRD]) begin
			dok = 1'b1;
		end else if (m == MODE_1S) begin
			dok = (d == '0);
		end else if (mode_flag(w, m)) begin
			dok = (d == w[F_DUMMY +: DUMMY_W]);
		end else begin
			dok = 1'b1;
		end
		cmd_ok = w[F_AVAIL] && dok && (!w[F_ADDRD] || local_addr(w, a) == w[F_LADDR +: BYTE_W]);
	endfunction

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	assign take = link.req && !ack_reg;
	assign desc_rd = (link.opcode == OP_DESC_RD);
	assign rd_hit = (link.opcode == BUSY_WORD[F_RDOP +: BYTE_W] && BUSY_WORD[F_RDOP +: BYTE_W] != OP_NONE &&
		cmd_ok(BUSY_WORD, link.addr, link.mode, link.dummy)) ||
		(link.opcode == LATCH_DESC[F_RDOP +: BYTE_W] && LATCH_DESC[F_RDOP +: BYTE_W] != OP_NONE &&
		cmd_ok(LATCH_DESC, link.addr, link.mode, link.dummy));
	// A 00h write opcode never matches, so the busy flag stays read-only
	assign wr_hit = link.opcode == LATCH_DESC[F_WROP +: BYTE_W] && LATCH_DESC[F_WROP +: BYTE_W] != OP_NONE &&
		cmd_ok(LATCH_DESC, link.addr, link.mode, link.dummy);
	assign prog_start = take && link.opcode == OP_PROGRAM && latch_reg && !busy_reg;

	// Status byte with each flag at its position and polarity
	always_comb begin
		stat_byte = '0;
		stat_byte[BUSY_WORD[F_POS +: POS_W]] = busy_reg ^ BUSY_WORD[F_POL];
		stat_byte[LATCH_DESC[F_POS +: POS_W]] = latch_reg ^ LATCH_DESC[F_POL];
	end

	// ----------------------------------------
	// Link answer, one cycle after the request is seen
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
			rdata_reg <= '0;
		end else if (take) begin
			ack_reg <= 1'b1;
			err_reg <= !(desc_rd || rd_hit || wr_hit || prog_start);
			if (desc_rd) begin
				rdata_reg <= link.addr[0] ? LATCH_DESC : BUSY_WORD;
			end else if (rd_hit) begin
				rdata_reg <= {24'h000000, stat_byte};
			end else begin
				rdata_reg <= '0;
			end
		end else begin
			ack_reg <= 1'b0;
		end
	end

	// Write-enable latch; a started program consumes it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch_reg <= 1'b0;
		end else if (prog_start) begin
			latch_reg <= 1'b0;
		end else if (take && wr_hit) begin
			if (LATCH_DESC[F_B29]) begin
				latch_reg <= 1'b1;
			end else begin
				latch_reg <= link.wdata[LATCH_DESC[F_POS +: POS_W]] ^ LATCH_DESC[F_POL];
			end
		end
	end

	// Write in progress for a fixed program time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_reg <= 1'b0;
			cnt_reg <= '0;
		end else if (prog_start) begin
			busy_reg <= 1'b1;
			cnt_reg <= PROG_CNT_W'(PROG_CYCLES - 1);
		end else if (busy_reg) begin
			if (cnt_reg == '0) begin
				busy_reg <= 1'b0;
			end else begin
				cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end

	assign link.ack = ack_reg;
	assign link.err = err_reg;
	assign link.rdata = rdata_reg;
	assign write_busy_flag = busy_reg;
	assign write_latch_flag = latch_reg;
endmodule

//--- verification/sbd_link_asserts.sv
`timescale 1ns/1ns
module sbd_link_asserts import sbd_pkg::*; (
	input logic pclk,
	input logic presetn,
	input logic req,
	input logic [7:0] opcode,
	input logic [31:0] addr,
	input sbd_mode_type mode,
	input logic [3:0] dummy,
	input logic [7:0] wdata,
	input logic ack,
	input logic err,
	input logic [31:0] rdata
);
	// ------
	// Link checks
	// ------
	localparam logic [7:0] BUSY_RD = BUSY_DESC[F_RDOP +: BYTE_W];
	localparam logic [7:0] LATCH_RD = LATCH_DESC[F_RDOP +: BYTE_W];
	localparam logic [7:0] LATCH_WR = LATCH_DESC[F_WROP +: BYTE_W];
	logic flagged;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Support bit of the busy poll in the current mode
	always_comb begin
		case (mode)
			MODE_8D: flagged = BUSY_DESC[F_M8D];
			MODE_8S: flagged = BUSY_DESC[F_M8S];
			MODE_4D: flagged = BUSY_DESC[F_M4D];
			MODE_4S: flagged = BUSY_DESC[F_M4S];
			default: flagged = 1'b0;
		endcase
	end
	AST_ANSWER: assert property ($rose(req) |=> ack ##1 !ack)
		else $error("link answer not one cycle after request");
	AST_HOLD: assert property (req && !ack |=> req && $stable(opcode) && $stable(addr) && $stable(dummy))
		else $error("request fields moved before answer");
	AST_BUSY_WORD: assert property (ack && opcode == OP_DESC_RD && !addr[0] |-> rdata[F_AVAIL] && !rdata[F_B29] && !err)
		else $error("busy descriptor word malformed");
	AST_LATCH_WORD: assert property (ack && opcode == OP_DESC_RD && addr[0] |-> rdata[F_AVAIL] && rdata[F_ADDRD])
		else $error("latch descriptor word malformed");
	AST_DUMMY: assert property (req && opcode == BUSY_RD && flagged |-> dummy == BUSY_DESC[F_DUMMY +: DUMMY_W])
		else $error("flagged mode poll with wrong dummy count");
	AST_SINGLE: assert property (req && opcode == BUSY_RD && mode == MODE_1S |-> dummy == 4'h0)
		else $error("single lane poll with dummies");
	AST_LOCAL_ADDR: assert property (req && (opcode == LATCH_RD || opcode == LATCH_WR) |-> addr[15:8] == LATCH_DESC[F_LADDR +: BYTE_W])
		else $error("latch register address misplaced");
	AST_POLL_REPLY: assert property (ack && opcode == BUSY_RD |-> rdata[31:8] == 24'h0 && !err)
		else $error("busy poll refused or reply malformed");
	AST_NO_NULL_OP: assert property (req |-> opcode != OP_NONE)
		else $error("request with unsupported opcode");
endmodule

//--- verification/status_bit_descriptor_decode_tb.sv
`timescale 1ns/1ns
module status_bit_descriptor_decode_tb import sbd_pkg::*; ;
	// ------
	// Signals
	// ------
	typedef struct packed {logic [32:0] v; logic [32:0] m;} sbd_note_type;
	localparam logic [32:0] M3 = 33'h100000007;
	localparam logic [32:0] ALL = 33'h1ffffffff;
	localparam int BPOS = S_BYTE + BUSY_DESC[F_POS +: POS_W];
	localparam int LPOS = S_BYTE + LATCH_DESC[F_POS +: POS_W];
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic busy_flag;
	logic latch_flag;
	logic [31:0] seed = 32'h18;
	logic [31:0] r;
	int n_fail = 0;
	int check_count = 0;
	int cycles = 0;
	int n_xfer = 0;
	int x;
	sbd_note_type notes[$];
	sbd_note_type cur;
	// Free-running bus clock
	always #10 pclk = ~pclk;
	sbd_link_if link();
	sbd_host u_sbd_host(.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.host));
	sbd_device u_sbd_device(.pclk(pclk), .presetn(presetn), .link(link.dev), .write_busy_flag(busy_flag),
		.write_latch_flag(latch_flag));
	sbd_link_asserts u_sbd_link_asserts(.pclk(pclk), .presetn(presetn), .req(link.req), .opcode(link.opcode),
		.addr(link.addr), .mode(link.mode), .dummy(link.dummy), .wdata(link.wdata), .ack(link.ack),
		.err(link.err), .rdata(link.rdata));
	// ------
	// Helpers
	// ------
	function automatic logic [31:0] xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// One APB transfer; the note is compared by the monitor
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] ev,
		input logic [32:0] em, output logic [31:0] q);
		@(posedge pclk);
		notes.push_back('{ev, em});
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] ev, input logic [32:0] em);
		logic [31:0] q;
		apb(1'b0, a, 32'h0, ev, em, q);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
		logic [31:0] q;
		apb(1'b1, a, d, {e, 32'h0}, 33'h100000000, q);
	endtask
	// Start an operation, then poll status until it settles
	task automatic run_op(input sbd_opc_type op, input sbd_mode_type m, input logic [3:0] dm, input logic [1:0] aw);
		logic [31:0] q;
		int i;
		wr(REG_CTRL, 32'h1 | (32'(op) << C_OP) | (32'(m) << C_MODE) | (32'(dm) << C_DUMMY) | (32'(aw) << C_AW), 1'b0);
		i = 0;
		do begin
			apb(1'b0, REG_STATUS, 32'h0, 33'h0, 33'h0, q);
			i++;
		end while (!(q[S_DONE] | q[S_ERR]) && i < 500);
	endtask
	// ------
	// Monitor and timeout
	// ------
	always @(posedge pclk) begin
		if (link.req === 1'b1 && link.ack === 1'b1)
			n_xfer++;
		if (link.req === 1'b1 && link.opcode === OP_PROGRAM && link.ack === 1'b0)
			check({32'h0, busy_flag}, 33'h0);
		if (psel && penable && pready === 1'b1) begin
			cur = notes.pop_front();
			if (cur.m != 33'h0)
				check({pslverr, prdata} & cur.m, cur.v & cur.m);
		end
		// Ceiling far above the few hundred cycles the scenarios need
		cycles++;
		if (cycles == 30000) begin
			n_fail++;
			conclude();
		end
	end
	// ------
	// Scenarios
	// ------
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(REG_CTRL, 33'h0, ALL);
		rd(REG_STATUS, 33'h0, ALL);
		rd(8'h10, 33'h100000000, ALL);
		wr(8'h14, 32'h0, 1'b1);
		run_op(OPC_FETCH, MODE_1S, 4'h0, AW8);
		rd(REG_STATUS, 33'h2, M3);
		rd(REG_DESC0, {1'b0, BUSY_DESC}, ALL);
		rd(REG_DESC1, {1'b0, LATCH_DESC}, ALL);
		wr(REG_DESC0, 32'hffffffff, 1'b0);
		rd(REG_DESC0, {1'b0, BUSY_DESC}, ALL);
		// Idle poll in every mode, random override for unflagged ones
		for (int k = 0; k < 5; k++) begin
			r = xorshift();
			run_op(OPC_POLL, sbd_mode_type'(k), r[3:0], 2'h2);
			rd(REG_STATUS, 33'h2 | (33'(BUSY_DESC[F_POL]) << BPOS), M3 | 33'h8 | (33'h1 << BPOS));
		end
		// Latch set, register address in byte 1 of 24 and 32 bit addresses
		for (int k = 1; k < 3; k++) begin
			r = xorshift();
			run_op(OPC_LATCH, sbd_mode_type'(r[6:4] % 5), r[3:0], 2'(k));
			rd(REG_STATUS, 33'h12 | (33'(!LATCH_DESC[F_POL]) << LPOS), M3 | 33'h10 | (33'h1 << LPOS));
			check({32'h0, latch_flag}, 33'h1);
		end
		// Byte-1 placement with 8-bit addressing: refused, no link traffic
		x = n_xfer;
		run_op(OPC_LATCH, MODE_1S, 4'h0, AW8);
		rd(REG_STATUS, 33'h6, M3);
		check(33'(n_xfer), 33'(x));
		// Program, then poll while the write runs
		run_op(OPC_PROGRAM, MODE_8S, 4'h0, 2'h2);
		rd(REG_STATUS, 33'h2, M3);
		run_op(OPC_POLL, MODE_4S, 4'h0, 2'h2);
		rd(REG_STATUS, 33'ha | (33'(!BUSY_DESC[F_POL]) << BPOS), M3 | 33'h8 | (33'h1 << BPOS));
		check({32'h0, busy_flag}, 33'h1);
		repeat (PROG_CYCLES + 10) @(posedge pclk);
		run_op(OPC_POLL, MODE_8D, 4'h3, 2'h2);
		rd(REG_STATUS, 33'h2, M3 | 33'h8);
		check({32'h0, latch_flag}, 33'h0);
		// Program without the latch set is refused
		run_op(OPC_PROGRAM, MODE_1S, 4'h0, 2'h2);
		rd(REG_STATUS, 33'h6, M3);
		conclude();
	end
endmodule
